//--- pkg/fspc_pkg.sv
// fspc_pkg: constants for the flash self-program controller.
// assumes a 200 MHz system clock and a 16-bit flash address pointer.
package fspc_pkg;

  // control register position and field bits
  localparam logic [7:0] FSPC_CTRL_ADDR     = 8'h37;
  localparam int         FSPC_BIT_IRQ_EN    = 7;
  localparam int         FSPC_BIT_BUSY      = 6;
  localparam int         FSPC_BIT_SIG_READ  = 5;
  localparam int         FSPC_BIT_REENABLE  = 4;
  localparam int         FSPC_BIT_LOCK_SET  = 3;
  localparam int         FSPC_BIT_PAGE_WR   = 2;
  localparam int         FSPC_BIT_PAGE_ER   = 1;
  localparam int         FSPC_BIT_ARM       = 0;
  localparam logic [7:0] FSPC_CTRL_RESET    = 8'h00;

  // lower-five-bit command codes that are accepted
  localparam logic [4:0] FSPC_CMD_LOAD      = 5'h01;
  localparam logic [4:0] FSPC_CMD_ERASE     = 5'h03;
  localparam logic [4:0] FSPC_CMD_WRITE     = 5'h05;
  localparam logic [4:0] FSPC_CMD_LOCK      = 5'h09;
  localparam logic [4:0] FSPC_CMD_REENABLE  = 5'h11;

  // arm windows in cycles
  localparam logic [2:0] FSPC_STORE_WINDOW  = 3'h4;
  localparam logic [2:0] FSPC_LOAD_WINDOW   = 3'h3;

  // signature row pointer addresses
  localparam logic [15:0] FSPC_SIG_ID1      = 16'h0000;
  localparam logic [15:0] FSPC_SIG_CAL      = 16'h0001;
  localparam logic [15:0] FSPC_SIG_ID2      = 16'h0002;
  localparam logic [15:0] FSPC_SIG_GAIN     = 16'h0003;
  localparam logic [15:0] FSPC_SIG_ID3      = 16'h0004;

  // flash geometry
  localparam int          FSPC_PAGE_HI      = 14;
  localparam int          FSPC_PAGE_LO      = 7;
  localparam int          FSPC_WORD_HI      = 6;
  localparam int          FSPC_WORD_LO      = 1;
  localparam int          FSPC_PAGE_WORDS   = 64;
  localparam logic [13:0] FSPC_BLOCKED_DURING_WRITING_SECTION_START   = 14'h3800;
  localparam logic [13:0] FSPC_BOOT_11      = 14'h3f00;
  localparam logic [13:0] FSPC_BOOT_10      = 14'h3e00;
  localparam logic [13:0] FSPC_BOOT_01      = 14'h3c00;
  localparam logic [13:0] FSPC_BOOT_00      = 14'h3800;
  localparam logic [11:0] FSPC_BOOT_SZ_11   = 12'h100;
  localparam logic [11:0] FSPC_BOOT_SZ_10   = 12'h200;
  localparam logic [11:0] FSPC_BOOT_SZ_01   = 12'h400;
  localparam logic [11:0] FSPC_BOOT_SZ_00   = 12'h800;

  // flash operation time, 3.7 ms to 4.5 ms; the midpoint is used
  localparam int FSPC_CLK_MHZ      = 200;
  localparam int FSPC_TPROG_MIN_US = 3700;
  localparam int FSPC_TPROG_MAX_US = 4500;
  localparam int FSPC_TPROG_CYCLES =
    (FSPC_TPROG_MIN_US + FSPC_TPROG_MAX_US) / 2 * FSPC_CLK_MHZ;

  // operation states
  typedef enum logic [1:0]
  {
    FSPC_IDLE  = 2'b00,
    FSPC_BUSY  = 2'b01
  } fspc_state_t;

endpackage

//--- logic/fspc_window.sv
// fspc_window: arm window counter, clears its flag after a set cycle count.
// assumes start pulses come from logic on the same clock.
`timescale 1ns/1ps
module fspc_window
#(
  parameter int LEN = 4
)
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic start,
  input  wire logic stop,
  output logic      open_win
);
  // refuse a window that the 3-bit counter cannot hold
  if (LEN < 1 || LEN > 7)
  begin : g_len_check
    $error("fspc_window: LEN out of range");
  end

  logic [2:0] count;

  // counts down from LEN after start; a stop closes at once
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      count    <= 3'h0;
      open_win <= 1'b0;
    end
    else if (start)
    begin
      count    <= 3'(LEN);
      open_win <= 1'b1;
    end
    else if (stop || count == 3'h1)
    begin
      count    <= 3'h0;
      open_win <= 1'b0;
    end
    else if (count != 3'h0)
      count <= count - 3'h1;
  end
endmodule

//--- logic/fspc_top.sv
// fspc_top: self-program control for the on-chip program flash.
// assumes the cpu core on clk_sys issues register writes, store and
// load strobes; flash array and fuses sit outside as plain ports.
//
// Operation
// - load in signature window returns the signature byte at pointer
// - signature and arm bits clear after the read or three cycles
// - with signature bits clear, load reads program flash normally
// - id bytes one, two, three sit at pointer 0, 2, 4
// - calibration byte at 1; sensor gain at 3
// - a running flash write finishes even through reset
// - erase, write, lock write take 3.7 to 4.5 ms each
// - boot fuses select boot size and start address
// - readable section pages 0x0000-0x37ff, blocked section above
// - page select comes from pointer bits 14 to 7
// - word select comes from pointer bits 6 to 1
// - page holds 64 words, pointer bit 0 unused
// - during readable-section erase or write only blocked section may be fetched; a blocked-section target halts all fetches
// - control register at 0x37 holds the documented bit layout
// - busy flag sets on readable erase or write, clears on reenable or page buffer load
// - arm bit opens store for four cycles, holds during erase or write
`timescale 1ns/1ps
module fspc_top
  import fspc_pkg::*;
#(
  parameter int PROG_CYCLES = FSPC_TPROG_CYCLES
)
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        power_good,
  input  wire logic [7:0]  ctrl_addr,
  input  wire logic        ctrl_write,
  input  wire logic [7:0]  ctrl_wdata,
  input  wire logic        eeprom_write_busy,
  input  wire logic        store_strobe,
  input  wire logic        load_strobe,
  input  wire logic [15:0] pointer,
  input  wire logic [15:0] store_data,
  input  wire logic [7:0]  flash_rdata,
  input  wire logic [7:0]  sig_id1,
  input  wire logic [7:0]  sig_id2,
  input  wire logic [7:0]  sig_id3,
  input  wire logic [7:0]  osc_cal,
  input  wire logic [7:0]  temp_sensor_gain_byte,
  input  wire logic        boot_size_fuse_hi,
  input  wire logic        boot_size_fuse_lo,
  input  wire logic [13:0] fetch_addr,
  output logic [7:0]       program_memory_control_reg,
  output logic [7:0]       load_data,
  output logic             load_valid,
  output logic             buf_we,
  output logic [5:0]       buf_word,
  output logic [15:0]      buf_wdata,
  output logic             buf_clear,
  output logic             op_erase,
  output logic             op_write,
  output logic             op_lock,
  output logic [7:0]       op_page,
  output logic [7:0]       lock_data,
  output logic             flash_active,
  output logic             fetch_stall,
  output logic [13:0]      boot_start,
  output logic [11:0]      boot_words
);
  // the operation timer is 24 bits wide
  if (PROG_CYCLES < 1 || PROG_CYCLES > 2**24 - 1)
  begin : g_prog_check
    $error("fspc_top: PROG_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // power-good pin synchroniser
  logic pg_meta;
  logic pg_sync;

  always_ff @(posedge clk_sys)
  begin
    pg_meta <= power_good;
    pg_sync <= pg_meta;
  end

  ////////////////////////////////////////////////////////////////////////
  // control register state
  fspc_state_t state;
  logic        irq_en;
  logic        busy_flag;
  logic        sig_sel;
  logic        reenable;
  logic        lock_set;
  logic        page_wr;
  logic        page_er;
  logic        arm;
  logic        store_open;
  logic        load_open;
  logic [23:0] prog_count;
  logic        op_rww;
  logic        op_lock_run;

  wire ctrl_hit  = ctrl_write && ctrl_addr == FSPC_CTRL_ADDR;
  wire idle      = state == FSPC_IDLE;
  // eeprom write blocks any control write
  wire take_ctrl = ctrl_hit && idle && !eeprom_write_busy;
  wire sig_cmd   = take_ctrl && ctrl_wdata[FSPC_BIT_SIG_READ]
                   && ctrl_wdata[FSPC_BIT_ARM];
  wire [4:0] cmd = ctrl_wdata[4:0];
  wire cmd_ok    = cmd == FSPC_CMD_LOAD || cmd == FSPC_CMD_ERASE
                   || cmd == FSPC_CMD_WRITE || cmd == FSPC_CMD_LOCK
                   || cmd == FSPC_CMD_REENABLE;
  wire store_cmd = take_ctrl && !ctrl_wdata[FSPC_BIT_SIG_READ] && cmd_ok;

  wire sig_active = sig_sel && arm && load_open;
  wire sig_load   = sig_active && load_strobe;
  wire st_go      = store_open && arm && idle && store_strobe;
  wire do_load    = st_go && !page_er && !page_wr && !lock_set && !reenable;
  wire do_erase   = st_go && page_er;
  wire do_write   = st_go && page_wr;
  wire do_lock    = st_go && lock_set;
  wire do_reen    = st_go && reenable;
  wire [7:0] page_sel = pointer[FSPC_PAGE_HI:FSPC_PAGE_LO];
  wire rww_page   = {page_sel, 6'h00} < FSPC_BLOCKED_DURING_WRITING_SECTION_START;
  wire prog_done  = state == FSPC_BUSY && prog_count == 24'h000001;

  // store arm window: four cycles from the command write
  fspc_window #(.LEN(int'(FSPC_STORE_WINDOW))) u_store_win
  (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .start    (store_cmd),
    .stop     (st_go),
    .open_win (store_open)
  );

  // signature window: three cycles, then the bits drop
  fspc_window #(.LEN(int'(FSPC_LOAD_WINDOW))) u_load_win
  (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .start    (sig_cmd),
    .stop     (sig_load),
    .open_win (load_open)
  );

  ////////////////////////////////////////////////////////////////////////
  // command bits; arm stays high while an erase or write runs
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      irq_en   <= 1'b0;
      sig_sel  <= 1'b0;
      reenable <= 1'b0;
      lock_set <= 1'b0;
      page_wr  <= 1'b0;
      page_er  <= 1'b0;
      arm      <= 1'b0;
    end
    else if (take_ctrl && (cmd_ok || sig_cmd))
    begin
      irq_en   <= ctrl_wdata[FSPC_BIT_IRQ_EN];
      sig_sel  <= ctrl_wdata[FSPC_BIT_SIG_READ];
      reenable <= ctrl_wdata[FSPC_BIT_REENABLE];
      lock_set <= ctrl_wdata[FSPC_BIT_LOCK_SET];
      page_wr  <= ctrl_wdata[FSPC_BIT_PAGE_WR];
      page_er  <= ctrl_wdata[FSPC_BIT_PAGE_ER];
      arm      <= 1'b1;
    end
    else if (take_ctrl)
      irq_en   <= ctrl_wdata[FSPC_BIT_IRQ_EN];
    else if (do_erase || do_write)
      arm      <= 1'b1;
    else if (prog_done || (arm && idle && !store_open && !load_open)
             || sig_load || (st_go && !do_erase && !do_write))
    begin
      // read done, store done, window lapsed or operation finished
      sig_sel  <= 1'b0;
      reenable <= 1'b0;
      lock_set <= 1'b0;
      page_wr  <= 1'b0;
      page_er  <= 1'b0;
      arm      <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operation timer; runs on through reset so a write completes
  always_ff @(posedge clk_sys)
  begin
    if (!pg_sync)
    begin
      state      <= FSPC_IDLE;
      prog_count <= 24'h000000;
    end
    else
    begin
      unique case (state)
        FSPC_IDLE:
        begin
          if (reset_n && (do_erase || do_write || do_lock))
          begin
            state      <= FSPC_BUSY;
            prog_count <= 24'(PROG_CYCLES);
          end
        end
        FSPC_BUSY:
        begin
          if (prog_count == 24'h000001)
            state <= FSPC_IDLE;
          prog_count <= prog_count - 24'h000001;
        end
        default:
          state <= FSPC_IDLE;
      endcase
    end
  end

  // what the running operation targets; held as a level, since the
  // op_lock strobe is gone long before a lock write finishes
  always_ff @(posedge clk_sys)
  begin
    if (!pg_sync)
    begin
      op_rww      <= 1'b0;
      op_lock_run <= 1'b0;
    end
    else if (idle && reset_n && (do_erase || do_write || do_lock))
    begin
      op_rww      <= rww_page && !do_lock;
      op_lock_run <= do_lock;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // readable-section busy flag; a new start beats a clear
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      busy_flag <= 1'b0;
    else if ((do_erase || do_write) && rww_page)
      busy_flag <= 1'b1;
    else if (do_reen || do_load)
      busy_flag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // load answers: signature row or normal flash byte
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      load_data  <= 8'h00;
      load_valid <= 1'b0;
    end
    else
    begin
      load_valid <= load_strobe;
      if (sig_load)
      begin
        unique case (pointer)
          FSPC_SIG_ID1:  load_data <= sig_id1;
          FSPC_SIG_CAL:  load_data <= osc_cal;
          FSPC_SIG_ID2:  load_data <= sig_id2;
          FSPC_SIG_GAIN: load_data <= temp_sensor_gain_byte;
          FSPC_SIG_ID3:  load_data <= sig_id3;
          default:       load_data <= 8'h00;
        endcase
      end
      else if (load_strobe)
        load_data <= flash_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // page buffer fill and flash operation strobes
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      buf_we    <= 1'b0;
      buf_word  <= 6'h00;
      buf_wdata <= 16'h0000;
      buf_clear <= 1'b1;
      op_erase  <= 1'b0;
      op_write  <= 1'b0;
      op_lock   <= 1'b0;
      op_page   <= 8'h00;
      lock_data <= 8'h00;
    end
    else
    begin
      buf_we    <= do_load;
      // pointer bit 0 ignored: word index is bits 6:1
      buf_word  <= pointer[FSPC_WORD_HI:FSPC_WORD_LO];
      buf_wdata <= store_data;
      buf_clear <= do_reen || (prog_done && page_wr);
      op_erase  <= do_erase && idle;
      op_write  <= do_write && idle;
      op_lock   <= do_lock && idle;
      lock_data <= store_data[7:0];
      if ((do_erase || do_write) && idle)
        op_page <= page_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // visible status, fetch guard, boot section decode
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      program_memory_control_reg <= FSPC_CTRL_RESET;
      flash_active               <= 1'b0;
      fetch_stall                <= 1'b0;
    end
    else
    begin
      program_memory_control_reg <= {irq_en, busy_flag, sig_sel, reenable,
                                     lock_set, page_wr, page_er, arm};
      flash_active <= !idle;
      // readable section blocked while busy; blocked target halts all
      fetch_stall  <= (!idle && !op_rww && !op_lock_run)
                      || ((busy_flag || (!idle && op_rww))
                          && fetch_addr < FSPC_BLOCKED_DURING_WRITING_SECTION_START);
    end
  end

  // boot fuses are static straps, sampled every cycle after release
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      boot_start <= FSPC_BOOT_00;
      boot_words <= FSPC_BOOT_SZ_00;
    end
    else
    begin
      unique case ({boot_size_fuse_hi, boot_size_fuse_lo})
        2'b11:
        begin
          boot_start <= FSPC_BOOT_11;
          boot_words <= FSPC_BOOT_SZ_11;
        end
        2'b10:
        begin
          boot_start <= FSPC_BOOT_10;
          boot_words <= FSPC_BOOT_SZ_10;
        end
        2'b01:
        begin
          boot_start <= FSPC_BOOT_01;
          boot_words <= FSPC_BOOT_SZ_01;
        end
        2'b00:
        begin
          boot_start <= FSPC_BOOT_00;
          boot_words <= FSPC_BOOT_SZ_00;
        end
      endcase
    end
  end
endmodule

//--- tb/fspc_top_props.sv
// fspc_top_props: port checks for the flash self-program controller.
// assumes it is bound onto fspc_top; one clock, reset_n synchronous.
`timescale 1ns/1ps
module fspc_top_props
#(
  parameter int PROG_CYCLES = 20
)
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        ctrl_write,
  input wire logic        store_strobe,
  input wire logic        load_strobe,
  input wire logic [15:0] pointer,
  input wire logic [15:0] store_data,
  input wire logic [7:0]  flash_rdata,
  input wire logic        boot_size_fuse_hi,
  input wire logic        boot_size_fuse_lo,
  input wire logic [7:0]  program_memory_control_reg,
  input wire logic [7:0]  load_data,
  input wire logic        load_valid,
  input wire logic        buf_we,
  input wire logic [5:0]  buf_word,
  input wire logic [15:0] buf_wdata,
  input wire logic        op_erase,
  input wire logic        op_write,
  input wire logic        op_lock,
  input wire logic [7:0]  op_page,
  input wire logic        flash_active,
  input wire logic        fetch_stall,
  input wire logic [13:0] boot_start,
  input wire logic [11:0] boot_words
);
  logic [31:0] act_cnt = 32'h0;
  logic [11:0] exp_words;
  logic [13:0] exp_start;
  // cycles since the last start pulse; not reset, since the flash timer
  // runs on through reset while flash_active itself is cleared
  always_ff @(posedge clk_sys)
    act_cnt <= (op_erase || op_write || op_lock) ? 32'h1 : act_cnt + 32'h1;
  // boot geometry expected from the fuse pair
  assign exp_words =
    12'h100 << (2'b11 ^ {boot_size_fuse_hi, boot_size_fuse_lo});
  assign exp_start = 14'(15'h4000 - {3'h0, exp_words});
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  property p_load_answer;
    load_strobe |=> load_valid;
  endproperty
  a_load_answer: assert property (p_load_answer)
    else $error("load strobe got no answer");
  property p_plain_load;
    load_strobe && !program_memory_control_reg[5] && !ctrl_write &&
    !$past(ctrl_write) && !$past(ctrl_write, 2) && !$past(ctrl_write, 3)
    |=> load_data == $past(flash_rdata);
  endproperty
  a_plain_load: assert property (p_plain_load)
    else $error("plain load did not return flash byte");
  property p_sig_close;
    $rose(program_memory_control_reg[5])
    |-> ##[1:4] !program_memory_control_reg[5];
  endproperty
  a_sig_close: assert property (p_sig_close)
    else $error("signature select stayed open");
  property p_buf_fill;
    buf_we |-> $past(store_strobe) && buf_word == $past(pointer[6:1]) &&
    buf_wdata == $past(store_data);
  endproperty
  a_buf_fill: assert property (p_buf_fill)
    else $error("page buffer word or data wrong");
  property p_op_page;
    op_erase || op_write |-> $past(store_strobe) &&
    op_page == $past(pointer[14:7]);
  endproperty
  a_op_page: assert property (p_op_page)
    else $error("page select wrong");
  property p_busy_set;
    (op_erase || op_write) && op_page < 8'he0
    |-> ##[1:2] program_memory_control_reg[6];
  endproperty
  a_busy_set: assert property (p_busy_set)
    else $error("busy flag not set");
  property p_op_time;
    $fell(flash_active)
    |-> act_cnt >= PROG_CYCLES - 1 && act_cnt <= PROG_CYCLES + 1;
  endproperty
  a_op_time: assert property (p_op_time)
    else $error("flash operation time wrong");
  property p_idle_fetch;
    !flash_active && !$past(flash_active) && !$past(flash_active, 2) &&
    !program_memory_control_reg[6]
    |-> !fetch_stall;
  endproperty
  a_idle_fetch: assert property (p_idle_fetch)
    else $error("fetch stalled while flash idle");
  property p_boot;
    {boot_size_fuse_hi, boot_size_fuse_lo} ==
    $past({boot_size_fuse_hi, boot_size_fuse_lo}, 2)
    |-> boot_words == exp_words && boot_start == exp_start;
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot section decode wrong");
endmodule

//--- tb/fspc_cpu_model.sv
// fspc_cpu_model: core side, issuing control writes, stores and loads.
// assumes the bench calls seq; drives change just after clk_sys rises.
`timescale 1ns/1ps
module fspc_cpu_model
  import fspc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic [7:0]  ctrl_rd,
  input  wire logic        ee_busy,
  output logic [7:0]       ctrl_addr,
  output logic             ctrl_write,
  output logic [7:0]       ctrl_wdata,
  output logic             store_strobe,
  output logic             load_strobe,
  output logic [15:0]      pointer,
  output logic [15:0]      store_data,
  output logic             hang
);
  // idle bus at time zero
  initial
  begin
    {ctrl_write, ctrl_wdata, store_strobe, load_strobe} = '0;
    {pointer, store_data, hang} = '0;
    ctrl_addr = FSPC_CTRL_ADDR;
  end
  // control write, then the instruction gap edges later; a gap past
  // the window is how a scenario asks for a late instruction
  task automatic seq(input logic [7:0] c, input logic [15:0] p,
                     input logic [15:0] d, input int gap, input bit ld);
    int n;
    n = 0;
    @(negedge clk_sys);
    while ((ctrl_rd[0] !== 1'b0 || ee_busy !== 1'b0) && n < 64)
    begin
      @(negedge clk_sys);
      n++;
    end
    hang |= (n == 64);
    @(posedge clk_sys);
    pointer <= p;
    store_data <= d;
    ctrl_wdata <= c;
    ctrl_write <= 1'b1;
    @(posedge clk_sys);
    ctrl_write <= 1'b0;
    repeat (gap - 1) @(posedge clk_sys);
    if (ld)
      load_strobe <= 1'b1;
    else
      store_strobe <= 1'b1;
    @(posedge clk_sys);
    load_strobe <= 1'b0;
    store_strobe <= 1'b0;
  endtask
endmodule

//--- tb/fspc_top_tb.sv
// fspc_top_tb: directed bench for the flash self-program controller.
// assumes a short flash time parameter and the core model as driver.
`timescale 1ns/1ps
module fspc_top_tb;
  localparam int PROG = 20;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic ee_busy = 1'b0;
  logic pg = 1'b1;
  logic fuse_hi = 1'b0;
  logic fuse_lo = 1'b0;
  logic [7:0] flash_rdata = 8'h5a;
  logic [13:0] fetch_addr = 14'h0100;
  logic [7:0] ctrl_addr, ctrl_wdata, ctrl_reg, load_data, op_page, lock_data;
  logic ctrl_write, store_strobe, load_strobe, hang, load_valid, buf_we;
  logic buf_clear, op_erase, op_write, op_lock, flash_active, fetch_stall;
  logic [15:0] pointer, store_data, buf_wdata, got_wd;
  logic [5:0] buf_word, got_word;
  logic [13:0] boot_start;
  logic [11:0] boot_words, w;
  logic [7:0] got_ld, got_page, got_lock;
  int n_lv, n_we, n_er, n_wr, n_lk, n_act, checks, bad_count;
  fspc_cpu_model cpu (.clk_sys(clk_sys), .ctrl_rd(ctrl_reg),
    .ee_busy(ee_busy), .ctrl_addr(ctrl_addr), .ctrl_write(ctrl_write),
    .ctrl_wdata(ctrl_wdata), .store_strobe(store_strobe),
    .load_strobe(load_strobe), .pointer(pointer), .store_data(store_data),
    .hang(hang));
  fspc_top #(.PROG_CYCLES(PROG)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .power_good(pg), .ctrl_addr(ctrl_addr), .ctrl_write(ctrl_write),
    .ctrl_wdata(ctrl_wdata), .eeprom_write_busy(ee_busy),
    .store_strobe(store_strobe), .load_strobe(load_strobe),
    .pointer(pointer), .store_data(store_data), .flash_rdata(flash_rdata),
    .sig_id1(8'h11), .osc_cal(8'h22), .sig_id2(8'h33),
    .temp_sensor_gain_byte(8'h44), .sig_id3(8'h55),
    .boot_size_fuse_hi(fuse_hi), .boot_size_fuse_lo(fuse_lo),
    .fetch_addr(fetch_addr), .program_memory_control_reg(ctrl_reg),
    .load_data(load_data), .load_valid(load_valid), .buf_we(buf_we),
    .buf_word(buf_word), .buf_wdata(buf_wdata), .buf_clear(buf_clear),
    .op_erase(op_erase), .op_write(op_write), .op_lock(op_lock),
    .op_page(op_page), .lock_data(lock_data), .flash_active(flash_active),
    .fetch_stall(fetch_stall), .boot_start(boot_start),
    .boot_words(boot_words));
  // 200 MHz clock
  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // pulse tally; reads pre-edge values so no race with the design
  always @(posedge clk_sys)
  begin
    n_lv += int'(load_valid === 1'b1);
    n_we += int'(buf_we === 1'b1);
    n_er += int'(op_erase === 1'b1);
    n_wr += int'(op_write === 1'b1);
    n_lk += int'(op_lock === 1'b1);
    n_act += int'(flash_active === 1'b1);
    if (load_valid === 1'b1) got_ld = load_data;
    if (buf_we === 1'b1) {got_word, got_wd} = {buf_word, buf_wdata};
    if (op_erase === 1'b1 || op_write === 1'b1) got_page = op_page;
    if (op_lock === 1'b1) got_lock = lock_data;
  end
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // bounded wait for the flash timer to finish
  task automatic wait_idle;
    int n;
    n = 0;
    while (flash_active !== 1'b0 && n < 200)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 200)
    begin
      bad_count++;
      complete_run();
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    settle(8);
    check("rst_ctrl", ctrl_reg, 0);
    check("rst_boot", {boot_start, boot_words}, {14'h3800, 12'h800});
    @(posedge clk_sys);
    reset_n <= 1'b1;
    cpu.seq(8'h00, 16'h0004, 16'h0, 4, 1);
    settle(2);
    check("plain_load", got_ld, flash_rdata);
    for (int i = 0; i < 5; i++)
    begin
      cpu.seq(8'h21, 16'(i), 16'h0, (i == 2) ? 3 : 1, 1);
      settle(2);
      check("sig_byte", got_ld, 8'(8'h11 * (i + 1)));
      check("sig_clear", ctrl_reg, 0);
    end
    cpu.seq(8'h21, 16'h0000, 16'h0, 4, 1);
    settle(2);
    check("late_load", {got_ld, 24'(n_lv)}, {flash_rdata, 24'd7});
    cpu.seq(8'h87, 16'h0, 16'h0, 5, 0);
    settle(2);
    check("bad_code", ctrl_reg, 8'h80);
    cpu.seq(8'h01, 16'h0086, 16'hbeef, 5, 0);
    settle(2);
    check("late_store", n_we, 0);
    cpu.seq(8'h01, 16'h0086, 16'hbeef, 4, 0);
    settle(2);
    check("fill", {n_we[7:0], 2'b0, got_word, got_wd}, 32'h0103beef);
    cpu.seq(8'h03, 16'h0280, 16'h0, 2, 0);
    settle(2);
    check("erase", {n_er[7:0], got_page}, 16'h0105);
    check("erase_busy", {ctrl_reg[6], ctrl_reg[0]}, 2'b11);
    check("rww_stall", fetch_stall, 1);
    wait_idle();
    check("op_time", n_act >= PROG - 1 && n_act <= PROG + 1, 1);
    settle(1);
    check("done_busy", {ctrl_reg[6], ctrl_reg[0]}, 2'b10);
    cpu.seq(8'h11, 16'h0, 16'h0, 1, 0);
    settle(2);
    check("reenable", ctrl_reg[6], 0);
    cpu.seq(8'h05, 16'h0300, 16'h0, 1, 0);
    settle(2);
    wait_idle();
    settle(1);
    check("write", {n_wr[7:0], got_page, ctrl_reg[6]}, 17'h0020d);
    cpu.seq(8'h01, 16'h0002, 16'h1234, 1, 0);
    settle(2);
    check("load_clr", {ctrl_reg[6], got_word}, 7'h01);
    cpu.seq(8'h05, 16'h7000, 16'h0, 1, 0);
    settle(2);
    check("blocked_during_writing_section", {got_page, ctrl_reg[6], fetch_stall}, 10'h381);
    @(posedge clk_sys);
    fetch_addr <= 14'h3900;
    reset_n <= 1'b0;
    settle(3);
    check("blocked_during_writing_section_fetch", fetch_stall, 0);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    settle(1);
    check("survive", flash_active, 1);
    wait_idle();
    @(posedge clk_sys);
    fetch_addr <= 14'h0100;
    cpu.seq(8'h09, 16'h0001, 16'h00c3, 1, 0);
    settle(2);
    check("lock", {n_lk[7:0], got_lock, ctrl_reg[0]}, 17'h00386);
    check("lock_run", {flash_active, fetch_stall}, 2'b10);
    wait_idle();
    for (int f = 0; f < 4; f++)
    begin
      @(posedge clk_sys);
      {fuse_hi, fuse_lo} <= 2'(f);
      settle(3);
      w = 12'h100 << (3 - f);
      check("boot", {boot_start, boot_words}, {14'(15'h4000 - 15'(w)), w});
    end
    check("cpu_hang", hang, 0);
    complete_run();
  end
endmodule
bind fspc_top fspc_top_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .clk_sys(clk_sys), .reset_n(reset_n), .ctrl_write(ctrl_write),
  .store_strobe(store_strobe), .load_strobe(load_strobe),
  .pointer(pointer), .store_data(store_data), .flash_rdata(flash_rdata),
  .boot_size_fuse_hi(boot_size_fuse_hi),
  .boot_size_fuse_lo(boot_size_fuse_lo),
  .program_memory_control_reg(program_memory_control_reg),
  .load_data(load_data), .load_valid(load_valid), .buf_we(buf_we),
  .buf_word(buf_word), .buf_wdata(buf_wdata), .op_erase(op_erase),
  .op_write(op_write), .op_lock(op_lock), .op_page(op_page),
  .flash_active(flash_active),
  .fetch_stall(fetch_stall), .boot_start(boot_start),
  .boot_words(boot_words));
